// ### verilog/cam_cfg_defines.svh
// Purpose: offsets, field positions, reset values and port stride of the config port
// Assumes: 8-bit register address, 16-bit data
// Notes: system space and port/chip space are selected by separate selects
`ifndef CAM_CFG_DEFINES_SVH
`define CAM_CFG_DEFINES_SVH

// port/chip space
`define OFF_CHIP_ROLE 8'h01
`define OFF_PORT_A_ID 8'h40
`define OFF_PORT_B_ID 8'h48
`define OFF_PORT_C_ID 8'h50
`define OFF_PORT_D_ID 8'h58
`define OFF_PORT_CONFIG_A 8'h41
`define OFF_PORT_TARGET_A 8'h42
`define PORT_STRIDE 8'h08
// system space
`define OFF_STATIC_CFG 8'h01
`define OFF_DYNAMIC_CFG 8'h02
`define OFF_CAM_DATA 8'h05
`define OFF_LOOKUP_CYC 8'h0C
`define OFF_CAM_PIN_CTRL 8'h12
`define OFF_SYS_TARGET 8'h14
`define OFF_PURGE_TS 8'h15
`define OFF_CURRENT_TS 8'h16
`define OFF_EVENT_STATUS 8'h17
// reset values
`define RST_CHIP_ROLE 16'h0001
`define RST_STATIC_CFG 16'h0000
`define RST_DYNAMIC_CFG 16'h0000
`define RST_LOOKUP_CYC 16'h0000
`define RST_CAM_PIN_CTRL 16'h000F
`define RST_PORT_CONFIG 16'h0000
`define RST_ZERO 16'h0000
// cam pin control fields
`define PIN_EC_BIT 0
`define PIN_CM_BIT 1
`define PIN_W_BIT 2
`define PIN_E_BIT 3
`define PIN_DIRECT_BIT 4
// other fields
`define DYN_CAM_ENABLE_BIT 0
`define STATIC_REJ_LOW_BIT 0
`define STATIC_SLOW_CAM_BIT 2
`define ROLE_MASTER 16'h0000
`define SYS_TGT_TIMESTAMP_INCREMENT_IN_BIT 0
`define SYS_TGT_FULL_INT_BIT 1
`define PORT_TGT_SA_BIT 0
`define PORT_TGT_DA_BIT 1
`define PORT_TGT_DA_INT_BIT 2
`define CAM_IDLE_PINS 4'hF

`endif

// ### verilog/cam_cfg_pkg.sv
// Purpose: types shared by the configuration port files
// Assumes: nothing
// Notes: constants live in cam_cfg_defines.svh
package cam_cfg_pkg;
	typedef enum logic [1:0] {
		SPACE_NONE,
		SPACE_SYSTEM,
		SPACE_PORT
	} space_type;
	typedef logic [15:0] word_type;
endpackage

// ### verilog/cam_pin_mux.sv
// Purpose: choose who drives the cam interface pins
// Assumes: all inputs registered upstream
// Notes: outputs are registered here
`timescale 1ns/1ps
`default_nettype none
`include "cam_cfg_defines.svh"
module cam_pin_mux (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// software side
	input wire logic [4:0] pin_ctrl_in,
	input wire logic [15:0] sw_data_in,
	// internal routine side
	input wire logic [3:0] int_ctrl_in,
	input wire logic [15:0] int_data_in,
	// pins
	output logic [3:0] ctrl_out,
	output logic [15:0] dq_out,
	output logic dq_oe_out
);
	logic [3:0] next_ctrl;
	logic [15:0] next_dq;
	logic next_oe;
	logic direct;

	always_comb begin
		direct = pin_ctrl_in[`PIN_DIRECT_BIT];
		if (direct) begin
			next_ctrl = pin_ctrl_in[3:0];
			next_dq = sw_data_in;
			// drive dq only for writes (w low)
			next_oe = ~pin_ctrl_in[`PIN_W_BIT];
		end else begin
			next_ctrl = int_ctrl_in;
			next_dq = int_data_in;
			next_oe = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl_out <= `CAM_IDLE_PINS;
			dq_out <= `RST_ZERO;
			dq_oe_out <= 1'b0;
		end else begin
			ctrl_out <= next_ctrl;
			dq_out <= next_dq;
			dq_oe_out <= next_oe;
		end
	end
endmodule
`default_nettype wire

// ### verilog/cam_event_unit.sv
// Purpose: timestamp counters and event interrupt
// Assumes: increment and full inputs synchronous to the clock
// Notes: interrupt output is a registered active-low level
`timescale 1ns/1ps
`default_nettype none
`include "cam_cfg_defines.svh"
module cam_event_unit #(
	parameter int NPORTS = 4
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// configuration
	input wire logic timestamp_increment_in_en_in,
	input wire logic full_int_en_in,
	input wire logic [NPORTS-1:0] da_int_en_in,
	// events
	input wire logic timestamp_increment_in_in,
	input wire logic full_n_in,
	input wire logic [NPORTS-1:0] da_done_in,
	// software access
	input wire logic purge_wr_in,
	input wire logic current_wr_in,
	input wire logic status_wr_in,
	input wire logic [15:0] wdata_in,
	// results
	output logic [15:0] purge_out,
	output logic [15:0] current_out,
	output logic [15:0] status_out,
	output logic irq_n_out
);
	logic [15:0] next_purge, next_current, next_status;
	logic next_irq_n, timestamp_increment_in_q, full_q, timestamp_increment_in_rise, full_fall;
	logic [15:0] ev;

	always_comb begin
		timestamp_increment_in_rise = timestamp_increment_in_in & ~timestamp_increment_in_q;
		full_fall = ~full_n_in & full_q;
		next_purge = purge_out;
		next_current = current_out;
		if (purge_wr_in)
			next_purge = wdata_in;
		else if (timestamp_increment_in_en_in && timestamp_increment_in_rise)
			next_purge = purge_out + 16'h0001;
		if (current_wr_in)
			next_current = wdata_in;
		else if (timestamp_increment_in_en_in && timestamp_increment_in_rise)
			next_current = current_out + 16'h0001;
		ev = 16'h0000;
		ev[0] = full_fall & full_int_en_in;
		ev[NPORTS:1] = da_done_in & da_int_en_in;
		// write-one-to-clear, a new event wins
		next_status = status_out;
		if (status_wr_in)
			next_status = status_out & ~wdata_in;
		next_status = next_status | ev;
		next_irq_n = ~(|next_status);
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			purge_out <= `RST_ZERO;
			current_out <= `RST_ZERO;
			status_out <= `RST_ZERO;
			irq_n_out <= 1'b1;
			timestamp_increment_in_q <= 1'b0;
			full_q <= 1'b1;
		end else begin
			purge_out <= next_purge;
			current_out <= next_current;
			status_out <= next_status;
			irq_n_out <= next_irq_n;
			timestamp_increment_in_q <= timestamp_increment_in_in;
			full_q <= full_n_in;
		end
	end
endmodule
`default_nettype wire

// ### verilog/cam_config_register_port.sv
// Purpose: host configuration registers and direct cam pin control
// Assumes: host bus signals synchronous to CLK_IN; writes last one cycle
// Notes: reads return data one cycle after a read strobe
`timescale 1ns/1ps
`default_nettype none
`include "cam_cfg_defines.svh"
module cam_config_register_port #(
	parameter int NPORTS = 4
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// host register port
	input wire logic PORT_CHIP_SELECT_N_IN,
	input wire logic SYSTEM_SELECT_N_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [15:0] WDATA_IN,
	input wire logic WR_N_IN,
	input wire logic RD_N_IN,
	output logic [15:0] RDATA_OUT,
	output logic RDATA_OE_OUT,
	// cam interface
	output logic CAM_RESET_N_OUT,
	output logic CAM_ENABLE_N_OUT,
	output logic CAM_WRITE_N_OUT,
	output logic CAM_COMMAND_MODE_N_OUT,
	output logic CAM_COMPARE_ENABLE_N_OUT,
	output logic [15:0] CAM_DQ_OUT,
	output logic CAM_DQ_OE_OUT,
	input wire logic CAM_FULL_N_IN,
	// internal routine side of the cam pins
	input wire logic [3:0] ROUTINE_CTRL_IN,
	input wire logic [15:0] ROUTINE_DATA_IN,
	input wire logic [3:0] DA_DONE_IN,
	// configuration seen by the filter core
	output logic MASTER_OUT,
	output logic FRAME_REJECT_LOW_OUT,
	output logic SLOW_CAM_OUT,
	output logic [15:0] LOOKUP_CYCLE_OUT,
	output logic [63:0] PORT_ID_OUT,
	output logic [3:0] CRC_CHECK_EN_OUT,
	output logic [3:0] SA_AUTO_EN_OUT,
	output logic [3:0] DA_AUTO_EN_OUT,
	// events
	input wire logic TIMESTAMP_INCREMENT_IN,
	output logic INTERRUPT_OUT_N
);
	// the fixed-width port buses below are laid out for four ports
	if (NPORTS != 4) begin : g_nports_check
		$error("NPORTS must be 4");
	end

	cam_cfg_pkg::space_type space;
	cam_cfg_pkg::word_type chip_role;
	cam_cfg_pkg::word_type next_chip_role;
	cam_cfg_pkg::word_type system_static_config;
	cam_cfg_pkg::word_type next_static;
	cam_cfg_pkg::word_type system_dynamic_config;
	cam_cfg_pkg::word_type next_dynamic;
	cam_cfg_pkg::word_type cam_data_word_zero;
	cam_cfg_pkg::word_type next_cam_data;
	cam_cfg_pkg::word_type lookup_cycle_timing;
	cam_cfg_pkg::word_type next_lookup;
	cam_cfg_pkg::word_type cam_pin_control;
	cam_cfg_pkg::word_type next_pin_ctrl;
	cam_cfg_pkg::word_type system_target;
	cam_cfg_pkg::word_type next_sys_target;
	cam_cfg_pkg::word_type port_id [NPORTS];
	cam_cfg_pkg::word_type next_port_id [NPORTS];
	cam_cfg_pkg::word_type port_config [NPORTS];
	cam_cfg_pkg::word_type next_port_config [NPORTS];
	cam_cfg_pkg::word_type port_target [NPORTS];
	cam_cfg_pkg::word_type next_port_target [NPORTS];
	cam_cfg_pkg::word_type rd_word;
	cam_cfg_pkg::word_type next_rdata;
	logic next_rdata_oe;
	logic wr;
	logic rd;
	logic sys_wr;
	logic port_wr;
	logic purge_wr;
	logic current_wr;
	logic status_wr;
	logic [15:0] purge_ts;
	logic [15:0] current_ts;
	logic [15:0] ev_status;
	logic [3:0] pin_ctrl_pins;
	logic [3:0] da_int_en;
	logic [63:0] next_id_bus;

	// decode which register space a strobe targets
	// both selects low is ambiguous, so such a strobe reaches nothing
	function automatic cam_cfg_pkg::space_type decode_space(
		input logic sys_n,
		input logic port_n
	);
		cam_cfg_pkg::space_type s;
		s = cam_cfg_pkg::SPACE_NONE;
		if (!sys_n && port_n)
			s = cam_cfg_pkg::SPACE_SYSTEM;
		else if (!port_n && sys_n)
			s = cam_cfg_pkg::SPACE_PORT;
		return s;
	endfunction

	// port index hit for a per-port register at a base offset
	function automatic logic port_hit(
		input logic [7:0] addr,
		input logic [7:0] base,
		input int idx
	);
		logic [7:0] a;
		a = base + 8'(idx * 8);
		return addr == a;
	endfunction

	// bus decode and register next values
	always_comb begin
		space = decode_space(SYSTEM_SELECT_N_IN, PORT_CHIP_SELECT_N_IN);
		wr = ~WR_N_IN;
		rd = ~RD_N_IN;
		sys_wr = wr && (space == cam_cfg_pkg::SPACE_SYSTEM);
		port_wr = wr && (space == cam_cfg_pkg::SPACE_PORT);
		next_chip_role = chip_role;
		next_static = system_static_config;
		next_dynamic = system_dynamic_config;
		next_cam_data = cam_data_word_zero;
		next_lookup = lookup_cycle_timing;
		next_pin_ctrl = cam_pin_control;
		next_sys_target = system_target;
		purge_wr = 1'b0;
		current_wr = 1'b0;
		status_wr = 1'b0;
		for (int i = 0; i < NPORTS; i++) begin
			next_port_id[i] = port_id[i];
			next_port_config[i] = port_config[i];
			next_port_target[i] = port_target[i];
		end
		if (port_wr) begin
			if (ADDR_IN == `OFF_CHIP_ROLE) begin
				next_chip_role = WDATA_IN;
			end
			for (int i = 0; i < NPORTS; i++) begin
				if (port_hit(ADDR_IN, `OFF_PORT_A_ID, i))
					next_port_id[i] = WDATA_IN;
				else if (port_hit(ADDR_IN, `OFF_PORT_CONFIG_A, i))
					next_port_config[i] = WDATA_IN;
				else if (port_hit(ADDR_IN, `OFF_PORT_TARGET_A, i))
					next_port_target[i] = WDATA_IN;
			end
		end
		if (sys_wr) begin
			if (ADDR_IN == `OFF_STATIC_CFG) begin
				next_static = WDATA_IN;
			end else if (ADDR_IN == `OFF_DYNAMIC_CFG) begin
				next_dynamic = WDATA_IN;
			end else if (ADDR_IN == `OFF_CAM_DATA) begin
				next_cam_data = WDATA_IN;
			end else if (ADDR_IN == `OFF_LOOKUP_CYC) begin
				next_lookup = WDATA_IN;
			end else if (ADDR_IN == `OFF_CAM_PIN_CTRL) begin
				// only the five pin bits are kept; the rest read as zero
				next_pin_ctrl = {11'h000, WDATA_IN[4:0]};
			end else if (ADDR_IN == `OFF_SYS_TARGET) begin
				next_sys_target = WDATA_IN;
			end else if (ADDR_IN == `OFF_PURGE_TS) begin
				purge_wr = 1'b1;
			end else if (ADDR_IN == `OFF_CURRENT_TS) begin
				current_wr = 1'b1;
			end else if (ADDR_IN == `OFF_EVENT_STATUS) begin
				status_wr = 1'b1;
			end
		end
	end

	// read mux: unmapped or unselected reads return zero
	always_comb begin
		rd_word = `RST_ZERO;
		if (space == cam_cfg_pkg::SPACE_PORT) begin
			if (ADDR_IN == `OFF_CHIP_ROLE)
				rd_word = chip_role;
			for (int i = 0; i < NPORTS; i++) begin
				if (port_hit(ADDR_IN, `OFF_PORT_A_ID, i))
					rd_word = port_id[i];
				else if (port_hit(ADDR_IN, `OFF_PORT_CONFIG_A, i))
					rd_word = port_config[i];
				else if (port_hit(ADDR_IN, `OFF_PORT_TARGET_A, i))
					rd_word = port_target[i];
			end
		end else if (space == cam_cfg_pkg::SPACE_SYSTEM) begin
			if (ADDR_IN == `OFF_STATIC_CFG)
				rd_word = system_static_config;
			else if (ADDR_IN == `OFF_DYNAMIC_CFG)
				rd_word = system_dynamic_config;
			else if (ADDR_IN == `OFF_CAM_DATA)
				rd_word = cam_data_word_zero;
			else if (ADDR_IN == `OFF_LOOKUP_CYC)
				rd_word = lookup_cycle_timing;
			else if (ADDR_IN == `OFF_CAM_PIN_CTRL)
				rd_word = cam_pin_control;
			else if (ADDR_IN == `OFF_SYS_TARGET)
				rd_word = system_target;
			else if (ADDR_IN == `OFF_PURGE_TS)
				rd_word = purge_ts;
			else if (ADDR_IN == `OFF_CURRENT_TS)
				rd_word = current_ts;
			else if (ADDR_IN == `OFF_EVENT_STATUS)
				rd_word = ev_status;
		end
		next_rdata = rd ? rd_word : `RST_ZERO;
		next_rdata_oe = rd && (space != cam_cfg_pkg::SPACE_NONE);
		for (int i = 0; i < NPORTS; i++) begin
			next_id_bus[i*16 +: 16] = next_port_id[i];
			da_int_en[i] = port_target[i][`PORT_TGT_DA_INT_BIT];
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			chip_role <= `RST_CHIP_ROLE;
			system_static_config <= `RST_STATIC_CFG;
			system_dynamic_config <= `RST_DYNAMIC_CFG;
			cam_data_word_zero <= `RST_ZERO;
			lookup_cycle_timing <= `RST_LOOKUP_CYC;
			cam_pin_control <= `RST_CAM_PIN_CTRL;
			system_target <= `RST_ZERO;
			for (int i = 0; i < NPORTS; i++) begin
				port_id[i] <= `RST_ZERO;
				port_config[i] <= `RST_PORT_CONFIG;
				port_target[i] <= `RST_ZERO;
			end
			RDATA_OUT <= `RST_ZERO;
			RDATA_OE_OUT <= 1'b0;
			CAM_RESET_N_OUT <= 1'b0;
			MASTER_OUT <= 1'b0;
			FRAME_REJECT_LOW_OUT <= 1'b0;
			SLOW_CAM_OUT <= 1'b0;
			LOOKUP_CYCLE_OUT <= `RST_LOOKUP_CYC;
			PORT_ID_OUT <= 64'h0000_0000_0000_0000;
			CRC_CHECK_EN_OUT <= 4'h0;
			SA_AUTO_EN_OUT <= 4'h0;
			DA_AUTO_EN_OUT <= 4'h0;
		end else begin
			chip_role <= next_chip_role;
			system_static_config <= next_static;
			system_dynamic_config <= next_dynamic;
			cam_data_word_zero <= next_cam_data;
			lookup_cycle_timing <= next_lookup;
			cam_pin_control <= next_pin_ctrl;
			system_target <= next_sys_target;
			for (int i = 0; i < NPORTS; i++) begin
				port_id[i] <= next_port_id[i];
				port_config[i] <= next_port_config[i];
				port_target[i] <= next_port_target[i];
				CRC_CHECK_EN_OUT[i] <= next_port_config[i][0];
				SA_AUTO_EN_OUT[i] <= next_port_target[i][`PORT_TGT_SA_BIT];
				DA_AUTO_EN_OUT[i] <= next_port_target[i][`PORT_TGT_DA_BIT];
			end
			RDATA_OUT <= next_rdata;
			RDATA_OE_OUT <= next_rdata_oe;
			// outputs follow next values so they change with their register
			CAM_RESET_N_OUT <= next_dynamic[`DYN_CAM_ENABLE_BIT];
			MASTER_OUT <= (next_chip_role == `ROLE_MASTER);
			FRAME_REJECT_LOW_OUT <= next_static[`STATIC_REJ_LOW_BIT];
			SLOW_CAM_OUT <= next_static[`STATIC_SLOW_CAM_BIT];
			LOOKUP_CYCLE_OUT <= next_lookup;
			PORT_ID_OUT <= next_id_bus;
		end
	end

	// software or internal routines drive the cam pins
	// pins lag a pin control write by two cycles: register, then mux flop
	cam_pin_mux pin_mux (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.pin_ctrl_in(cam_pin_control[4:0]),
		.sw_data_in(cam_data_word_zero),
		.int_ctrl_in(ROUTINE_CTRL_IN),
		.int_data_in(ROUTINE_DATA_IN),
		.ctrl_out(pin_ctrl_pins),
		.dq_out(CAM_DQ_OUT),
		.dq_oe_out(CAM_DQ_OE_OUT)
	);

	// pin_ctrl_pins are registered inside the mux
	assign CAM_ENABLE_N_OUT = pin_ctrl_pins[`PIN_E_BIT];
	assign CAM_WRITE_N_OUT = pin_ctrl_pins[`PIN_W_BIT];
	assign CAM_COMMAND_MODE_N_OUT = pin_ctrl_pins[`PIN_CM_BIT];
	assign CAM_COMPARE_ENABLE_N_OUT = pin_ctrl_pins[`PIN_EC_BIT];

	// timestamp counters and event status
	cam_event_unit #(
		.NPORTS(NPORTS)
	) events (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.timestamp_increment_in_en_in(system_target[`SYS_TGT_TIMESTAMP_INCREMENT_IN_BIT]),
		.full_int_en_in(system_target[`SYS_TGT_FULL_INT_BIT]),
		.da_int_en_in(da_int_en),
		.timestamp_increment_in_in(TIMESTAMP_INCREMENT_IN),
		.full_n_in(CAM_FULL_N_IN),
		.da_done_in(DA_DONE_IN),
		.purge_wr_in(purge_wr),
		.current_wr_in(current_wr),
		.status_wr_in(status_wr),
		.wdata_in(WDATA_IN),
		.purge_out(purge_ts),
		.current_out(current_ts),
		.status_out(ev_status),
		.irq_n_out(INTERRUPT_OUT_N)
	);
endmodule
`default_nettype wire

// ### testbench/cam_cfg_checker.sv
// Purpose: timing checks on the configuration port pins
// Assumes: one clock, synchronous reset on RST_IN
// Notes: bound to every instance of the port
`timescale 1ns/1ps
`default_nettype none
module cam_cfg_checker #(
	parameter int NPORTS = 4
) (
	// host side
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic PORT_CHIP_SELECT_N_IN,
	input wire logic SYSTEM_SELECT_N_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [15:0] WDATA_IN,
	input wire logic WR_N_IN,
	input wire logic RD_N_IN,
	input wire logic [15:0] RDATA_OUT,
	input wire logic RDATA_OE_OUT,
	// cam and config side
	input wire logic CAM_RESET_N_OUT,
	input wire logic CAM_ENABLE_N_OUT,
	input wire logic CAM_WRITE_N_OUT,
	input wire logic CAM_COMMAND_MODE_N_OUT,
	input wire logic CAM_COMPARE_ENABLE_N_OUT,
	input wire logic [15:0] CAM_DQ_OUT,
	input wire logic CAM_DQ_OE_OUT,
	input wire logic [3:0] ROUTINE_CTRL_IN,
	input wire logic MASTER_OUT,
	input wire logic FRAME_REJECT_LOW_OUT,
	input wire logic SLOW_CAM_OUT,
	input wire logic [15:0] LOOKUP_CYCLE_OUT
);
	wire logic sys_wr;
	wire logic port_wr;
	wire logic one_sel;
	wire logic [3:0] pins;
	logic [15:0] word;
	logic [15:0] next_word;
	assign one_sel = PORT_CHIP_SELECT_N_IN ^ SYSTEM_SELECT_N_IN;
	assign sys_wr = !WR_N_IN && !SYSTEM_SELECT_N_IN && PORT_CHIP_SELECT_N_IN;
	assign port_wr = !WR_N_IN && SYSTEM_SELECT_N_IN && !PORT_CHIP_SELECT_N_IN;
	assign pins = {CAM_ENABLE_N_OUT, CAM_WRITE_N_OUT,
		CAM_COMMAND_MODE_N_OUT, CAM_COMPARE_ENABLE_N_OUT};
	// mirror of the cam data word register
	always_comb begin
		next_word = word;
		if (RST_IN) begin
			next_word = 16'h0000;
		end else if (sys_wr && ADDR_IN == 8'h05) begin
			next_word = WDATA_IN;
		end
	end
	always_ff @(posedge CLK_IN) begin
		word <= next_word;
	end
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);
	chk_read_answer: assert property (!RD_N_IN && one_sel |=> RDATA_OE_OUT)
		else $error("selected read gave no answer");
	chk_refused_read: assert property (!RD_N_IN && !one_sel
		|=> !RDATA_OE_OUT && RDATA_OUT == 16'h0000)
		else $error("unselected read answered");
	chk_master_role: assert property (port_wr && ADDR_IN == 8'h01
		&& WDATA_IN == 16'h0000 |=> MASTER_OUT)
		else $error("chip role write did not make master");
	chk_static_cfg: assert property (sys_wr && ADDR_IN == 8'h01 |=>
		FRAME_REJECT_LOW_OUT == $past(WDATA_IN[0])
		&& SLOW_CAM_OUT == $past(WDATA_IN[2]))
		else $error("static config outputs wrong");
	chk_lookup_cyc: assert property (sys_wr && ADDR_IN == 8'h0C |=>
		LOOKUP_CYCLE_OUT == $past(WDATA_IN))
		else $error("lookup cycle output wrong");
	chk_cam_reset: assert property (sys_wr && ADDR_IN == 8'h02 |=>
		CAM_RESET_N_OUT == $past(WDATA_IN[0]))
		else $error("cam reset pin wrong");
	chk_direct_pins: assert property (sys_wr && ADDR_IN == 8'h12
		&& WDATA_IN[4] |=> ##1 pins == $past(WDATA_IN[3:0], 2))
		else $error("direct pin control not on pins");
	chk_routine_pins: assert property (sys_wr && ADDR_IN == 8'h12
		&& !WDATA_IN[4] |=> ##1 pins == $past(ROUTINE_CTRL_IN))
		else $error("routine lost the cam pins");
	chk_dq_word: assert property (CAM_DQ_OE_OUT |->
		CAM_DQ_OUT == $past(word))
		else $error("cam bus not the data word");
endmodule
bind cam_config_register_port cam_cfg_checker #(.NPORTS(NPORTS)) chk_inst (
	.CLK_IN(CLK_IN), .RST_IN(RST_IN),
	.PORT_CHIP_SELECT_N_IN(PORT_CHIP_SELECT_N_IN),
	.SYSTEM_SELECT_N_IN(SYSTEM_SELECT_N_IN),
	.ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_N_IN(WR_N_IN),
	.RD_N_IN(RD_N_IN), .RDATA_OUT(RDATA_OUT), .RDATA_OE_OUT(RDATA_OE_OUT),
	.CAM_RESET_N_OUT(CAM_RESET_N_OUT), .CAM_ENABLE_N_OUT(CAM_ENABLE_N_OUT),
	.CAM_WRITE_N_OUT(CAM_WRITE_N_OUT),
	.CAM_COMMAND_MODE_N_OUT(CAM_COMMAND_MODE_N_OUT),
	.CAM_COMPARE_ENABLE_N_OUT(CAM_COMPARE_ENABLE_N_OUT),
	.CAM_DQ_OUT(CAM_DQ_OUT), .CAM_DQ_OE_OUT(CAM_DQ_OE_OUT),
	.ROUTINE_CTRL_IN(ROUTINE_CTRL_IN), .MASTER_OUT(MASTER_OUT),
	.FRAME_REJECT_LOW_OUT(FRAME_REJECT_LOW_OUT), .SLOW_CAM_OUT(SLOW_CAM_OUT),
	.LOOKUP_CYCLE_OUT(LOOKUP_CYCLE_OUT)
);
`default_nettype wire

// ### testbench/cam_chain_model.sv
// Purpose: behavioural chain of cams behind the cam pins
// Assumes: pins registered on the bench clock
// Notes: logs every command word taken; full flag follows full_req_in while cam_reset_n_in is high
`timescale 1ns/1ps
`default_nettype none
module cam_chain_model (
	// pins from the port
	input wire logic clk_in,
	input wire logic cam_reset_n_in,
	input wire logic enable_n_in,
	input wire logic write_n_in,
	input wire logic command_n_in,
	input wire logic [15:0] dq_in,
	input wire logic dq_oe_in,
	// bench control and flag back
	input wire logic full_req_in,
	output logic full_n_out
);
	logic enable_q = 1'b1;
	logic [15:0] cmd_log [$];
	// a cam takes the bus when enable falls
	always @(posedge clk_in) begin
		enable_q <= enable_n_in;
		if (enable_q && !enable_n_in && cam_reset_n_in && !write_n_in
			&& !command_n_in && dq_oe_in) begin
			cmd_log.push_back(dq_in);
		end
	end
	// a chain held in reset never reports full
	assign full_n_out = !(cam_reset_n_in && full_req_in);
endmodule
`default_nettype wire

// ### testbench/cam_config_register_port_tb_top.sv
// Purpose: scenarios for the configuration register port
// Assumes: cam chain model on the cam pins
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module cam_config_register_port_tb_top;
	logic clk = 1'b0;
	logic rst, ps_n, ss_n, wr_n, rd_n, timestamp_increment_in, full_req;
	logic [7:0] addr;
	logic [15:0] wdata, rt_data, rdata, dq, lookup;
	logic [3:0] rt_ctrl, da_done, crc_en, sa_en, da_en;
	logic rdata_oe, cam_rst_n, en_n, we_n, cm_n, ec_n, dq_oe, full_n;
	logic master, rej_low, slow, irq_n;
	logic [63:0] port_id;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [15:0] sent [$];
	cam_config_register_port uut (.CLK_IN(clk), .RST_IN(rst),
		.PORT_CHIP_SELECT_N_IN(ps_n), .SYSTEM_SELECT_N_IN(ss_n),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_N_IN(wr_n), .RD_N_IN(rd_n),
		.RDATA_OUT(rdata), .RDATA_OE_OUT(rdata_oe),
		.CAM_RESET_N_OUT(cam_rst_n), .CAM_ENABLE_N_OUT(en_n),
		.CAM_WRITE_N_OUT(we_n), .CAM_COMMAND_MODE_N_OUT(cm_n),
		.CAM_COMPARE_ENABLE_N_OUT(ec_n), .CAM_DQ_OUT(dq),
		.CAM_DQ_OE_OUT(dq_oe), .CAM_FULL_N_IN(full_n),
		.ROUTINE_CTRL_IN(rt_ctrl), .ROUTINE_DATA_IN(rt_data),
		.DA_DONE_IN(da_done), .MASTER_OUT(master),
		.FRAME_REJECT_LOW_OUT(rej_low), .SLOW_CAM_OUT(slow),
		.LOOKUP_CYCLE_OUT(lookup), .PORT_ID_OUT(port_id),
		.CRC_CHECK_EN_OUT(crc_en), .SA_AUTO_EN_OUT(sa_en),
		.DA_AUTO_EN_OUT(da_en), .TIMESTAMP_INCREMENT_IN(timestamp_increment_in),
		.INTERRUPT_OUT_N(irq_n));
	cam_chain_model cam (.clk_in(clk), .cam_reset_n_in(cam_rst_n),
		.enable_n_in(en_n), .write_n_in(we_n), .command_n_in(cm_n),
		.dq_in(dq), .dq_oe_in(dq_oe), .full_req_in(full_req),
		.full_n_out(full_n));
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("mismatch run length expected end seen hang");
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e, g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic p, s, input logic [7:0] a,
		input logic [15:0] d);
		ps_n = p;
		ss_n = s;
		addr = a;
		wdata = d;
		wr_n = 1'b0;
		step(1);
		wr_n = 1'b1;
		ps_n = 1'b1;
		ss_n = 1'b1;
	endtask
	task automatic rd(input logic p, s, input logic [7:0] a,
		input logic [15:0] e, input string nm);
		ps_n = p;
		ss_n = s;
		addr = a;
		rd_n = 1'b0;
		step(1);
		rd_n = 1'b1;
		ps_n = 1'b1;
		ss_n = 1'b1;
		chk(nm, e, rdata);
		chk("read enable", p ^ s, rdata_oe);
	endtask
	task automatic pins(input logic [3:0] e);
		chk("cam pins", e, {en_n, we_n, cm_n, ec_n});
	endtask
	task automatic cmd(input logic [15:0] d);
		wr(1, 0, 8'h05, d);
		wr(1, 0, 8'h12, 16'h0019);
		wr(1, 0, 8'h12, 16'h0011);
		step(1);
		pins(4'h1);
		chk("cam bus", d, dq);
		chk("cam bus drive", 1, dq_oe);
		wr(1, 0, 8'h12, 16'h0019);
		sent.push_back(d);
	endtask
	task automatic t_reset();
		chk("cam reset pin", 0, cam_rst_n);
		chk("interrupt", 1, irq_n);
		pins(4'hF);
		rd(0, 1, 8'h01, 16'h0001, "chip role");
		rd(1, 0, 8'h12, 16'h000F, "pin control");
		for (int i = 0; i < 4; i++) begin
			rd(0, 1, 8'h41 + 8'(8 * i), 16'h0000, "port config");
		end
		chk("crc enables", 0, crc_en);
	endtask
	task automatic t_config();
		wr(1, 0, 8'h01, 16'h0005);
		rd(0, 1, 8'h01, 16'h0001, "chip role kept");
		rd(1, 0, 8'h01, 16'h0005, "static config");
		chk("reject low", 1, rej_low);
		chk("slow cam", 1, slow);
		wr(0, 1, 8'h01, 16'h0000);
		step(2);
		chk("master", 1, master);
		wr(1, 0, 8'h0C, 16'h0020);
		wr(1, 0, 8'h02, 16'h0001);
		step(2);
		chk("lookup cycle", 16'h0020, lookup);
		chk("cam reset pin", 1, cam_rst_n);
		rd(1, 1, 8'h01, 16'h0000, "no select");
		rd(0, 0, 8'h01, 16'h0000, "both selects");
		rd(1, 0, 8'h30, 16'h0000, "unmapped");
	endtask
	task automatic t_port_ids();
		for (int i = 0; i < 4; i++) begin
			wr(0, 1, 8'h40 + 8'(8 * i), 16'h0020 + 16'(i));
		end
		wr(0, 0, 8'h40, 16'hBEEF);
		step(2);
		for (int i = 0; i < 4; i++) begin
			chk("port id", 16'h0020 + 16'(i), port_id[16 * i +: 16]);
			rd(0, 1, 8'h40 + 8'(8 * i), 16'h0020 + 16'(i), "id");
		end
		wr(0, 1, 8'h41, 16'h0001);
		chk("crc enable", 4'h1, crc_en);
	endtask
	task automatic t_direct();
		rt_ctrl = 4'h6;
		rt_data = 16'h1234;
		wr(1, 0, 8'h12, 16'h000F);
		wr(1, 0, 8'h12, 16'h000F);
		wr(1, 0, 8'h12, 16'h000D);
		step(2);
		pins(4'h6);
		chk("routine bus", 16'h1234, dq);
		wr(1, 0, 8'h12, 16'h001D);
		wr(1, 0, 8'h12, 16'h0015);
		step(1);
		pins(4'h5);
		chk("read cycle drive", 0, dq_oe);
		wr(1, 0, 8'h12, 16'h001D);
		step(1);
		pins(4'hD);
		cmd(16'h0228);
		cmd(16'hFFFF);
		cmd(16'h0200);
		cmd(16'h0000);
		cmd(16'h0208);
		cmd(16'h0000);
		cmd(16'h0200);
		cmd(16'h0000);
		cmd(16'h0200);
		cmd(16'h8011);
		cmd(16'h0200);
		cmd(16'h8041);
		wr(1, 0, 8'h12, 16'h001F);
		wr(1, 0, 8'h12, 16'h001F);
		wr(1, 0, 8'h12, 16'h000F);
		wr(1, 0, 8'h12, 16'h000F);
		step(2);
		pins(4'h6);
		chk("bus released", 0, dq_oe);
		chk("cam words", sent.size(), cam.cmd_log.size());
		foreach (sent[i]) chk("cam word", sent[i], cam.cmd_log[i]);
	endtask
	task automatic t_events();
		wr(1, 0, 8'h14, 16'h0003);
		timestamp_increment_in = 1'b1;
		step(2);
		timestamp_increment_in = 1'b0;
		step(2);
		rd(1, 0, 8'h15, 16'h0001, "purge stamp");
		rd(1, 0, 8'h16, 16'h0001, "current stamp");
		full_req = 1'b1;
		step(3);
		chk("interrupt", 0, irq_n);
		rd(1, 0, 8'h17, 16'h0001, "event status");
		full_req = 1'b0;
		wr(1, 0, 8'h17, 16'h0001);
		step(2);
		chk("interrupt", 1, irq_n);
		wr(0, 1, 8'h42, 16'h0007);
		step(2);
		chk("sa enable", 4'h1, sa_en);
		chk("da enable", 4'h1, da_en);
		da_done = 4'h1;
		step(1);
		da_done = 4'h0;
		step(2);
		chk("interrupt", 0, irq_n);
		rd(1, 0, 8'h17, 16'h0002, "event status");
	endtask
	initial begin
		rst = 1'b1;
		ps_n = 1'b1;
		ss_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		addr = 8'h00;
		wdata = 16'h0000;
		rt_ctrl = 4'hF;
		rt_data = 16'h0000;
		da_done = 4'h0;
		timestamp_increment_in = 1'b0;
		full_req = 1'b0;
		step(8);
		rst = 1'b0;
		t_reset();
		t_config();
		t_port_ids();
		t_direct();
		t_events();
		tally_and_finish();
	end
endmodule
`default_nettype wire
